// File: bld_top.v
// Load disconnect controller with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
`include "bld_regs.vh"

module bld_top #(
    parameter integer CLK_HZ = `BLD_CLK_HZ
) (
    // Clock and reset
    input wire clock_i,
    input wire reset_i,
    // Avalon-MM slave
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    // Remote terminal, comparator and program pins
    input wire remote_high_i,
    input wire remote_low_n_i,
    input wire under_voltage_i,
    input wire over_voltage_i,
    input wire restart_ok_i,
    input wire above_52v_i,
    input wire program_pin_n_i,
    // Comparator reference levels
    output reg [9:0] shutdown_level_o,
    output reg [9:0] restart_level_o,
    // Switch, alarm and wireless enable
    output reg load_on_o,
    output reg alarm_o,
    output reg wireless_en_o
);

    // ==========================================================
    // State codes
    localparam [2:0] ST_ON = 3'h1;
    localparam [2:0] ST_OFF = 3'h2;
    localparam [2:0] ST_LOCK = 3'h4;

    // ==========================================================
    // Pin synchronisers
    localparam integer NSYNC = 6;
    wire [NSYNC-1:0] pins_raw;
    reg [NSYNC-1:0] sync_a;
    reg [NSYNC-1:0] sync_b;
    assign pins_raw = {~program_pin_n_i, above_52v_i, restart_ok_i,
                       over_voltage_i, under_voltage_i,
                       remote_high_i | ~remote_low_n_i};

    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
        end else begin
            sync_a <= pins_raw;
            sync_b <= sync_a;
        end
    end

    wire remote_on = sync_b[0];
    wire uv = sync_b[1];
    wire ov = sync_b[2];
    wire rest_ok = sync_b[3];
    wire above_52 = sync_b[4];
    wire program_pin = sync_b[5];

    // ==========================================================
    // One-second tick
    wire tick;

    bld_tick #(
        .CLK_HZ(CLK_HZ)
    ) u_tick (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .tick_o(tick)
    );

    // ==========================================================
    // Register slave, one wait cycle per access
    reg [1:0] mode;
    reg [3:0] preset;
    reg user_lvl;
    reg ack;
    reg program_pin_q;
    wire req = avs_read_i | avs_write_i;
    wire take = req & ~ack;
    // Writes land on the edge where the master sees waitrequest low
    wire wr_go = avs_write_i & ack;
    wire lithium = (mode == `BLD_MODE_LITHIUM);
    wire relay = (mode == `BLD_MODE_RELAY);

    assign avs_waitrequest_o = req & ~ack;

    reg [2:0] state;
    reg [6:0] timer;
    reg [1:0] tries;
    reg ov_off;
    reg blink;

    wire [31:0] ctrl_word = {29'h00000000, wireless_en_o, mode};
    wire [31:0] lvl_word = {1'b0, user_lvl, preset, restart_level_o,
                            6'h00, shutdown_level_o};
    wire [31:0] stat_word = {16'h0000, 1'b0, timer, tries, ov_off,
                             alarm_o, load_on_o, state};

    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ack <= 1'b0;
            avs_readdata_o <= 32'h00000000;
        end else begin
            ack <= take;
            if (take && avs_read_i) begin
                case (avs_address_i)
                    `BLD_OFS_CTRL: avs_readdata_o <= ctrl_word;
                    `BLD_OFS_LEVELS: avs_readdata_o <= lvl_word;
                    `BLD_OFS_STATUS: avs_readdata_o <= stat_word;
                    default: avs_readdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Mode and level pair; a write takes effect on its accepting edge
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mode <= `BLD_MODE_BUZZER;
            preset <= 4'h0;
            user_lvl <= 1'b0;
            shutdown_level_o <= `BLD_RST_SHUTDOWN;
            restart_level_o <= `BLD_RST_RESTART;
        end else if (wr_go) begin
            if (avs_address_i == `BLD_OFS_CTRL) begin
                // Code 3 is not a mode; keep the old one
                if (avs_writedata_i[1:0] != 2'h3) begin
                    mode <= avs_writedata_i[1:0];
                end
            end
            if (avs_address_i == `BLD_OFS_LEVELS) begin
                shutdown_level_o <= avs_writedata_i[9:0];
                restart_level_o <= avs_writedata_i[25:16];
                preset <= avs_writedata_i[29:26];
                user_lvl <= avs_writedata_i[`BLD_LVL_USER_BIT];
            end
        end
    end

    // Software may only clear wireless enable; the program pin sets it.
    // A pin edge in the same cycle as the clearing write wins.
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            program_pin_q <= 1'b0;
            wireless_en_o <= 1'b1;
        end else begin
            program_pin_q <= program_pin;
            if (program_pin && !program_pin_q) begin
                wireless_en_o <= 1'b1;
            end else if (wr_go && avs_address_i == `BLD_OFS_CTRL &&
                         !avs_writedata_i[`BLD_CTRL_WLESS_BIT]) begin
                wireless_en_o <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Switch control
    wire tmr_max = (timer == 7'h7F);
    wire [6:0] timer_inc = tmr_max ? timer : timer + 7'h01;
    wire uv_live = uv & ~lithium;
    wire off_cause = uv_live | ~remote_on;

    reg [2:0] next_state;
    reg [6:0] next_timer;
    reg [1:0] next_tries;
    reg next_ov_off;
    reg next_load;

    always @* begin
        next_state = state;
        next_timer = timer;
        next_tries = tries;
        next_ov_off = ov_off;
        next_load = load_on_o;
        case (state)
            ST_ON: begin
                if (ov) begin
                    next_state = ST_OFF;
                    next_load = 1'b0;
                    next_ov_off = 1'b1;
                    next_timer = 7'h00;
                end else if (lithium) begin
                    next_timer = 7'h00;
                    if (!remote_on) begin
                        next_load = 1'b0;
                        next_tries = (tries == `BLD_MAX_TRIES) ? tries : tries + 2'h1;
                        // Third reclose that fails again locks the switch out
                        next_state = (tries == `BLD_MAX_TRIES) ? ST_LOCK : ST_OFF;
                    end
                end else if (!off_cause) begin
                    next_timer = 7'h00;
                end else if (tick) begin
                    next_timer = timer_inc;
                    if (timer_inc >= `BLD_T_OFF) begin
                        next_state = ST_OFF;
                        next_load = 1'b0;
                        next_timer = 7'h00;
                        next_ov_off = 1'b0;
                    end
                end
            end
            ST_OFF: begin
                if (ov) begin
                    next_load = 1'b0;
                    next_ov_off = 1'b1;
                    next_timer = 7'h00;
                end else if (lithium) begin
                    if (tick && timer < `BLD_T_HOLD) begin
                        next_timer = timer_inc;
                    end
                    if (timer >= `BLD_T_HOLD && remote_on) begin
                        next_state = ST_ON;
                        next_load = 1'b1;
                        next_timer = 7'h00;
                        next_ov_off = 1'b0;
                    end
                end else if (!(remote_on && rest_ok)) begin
                    next_timer = 7'h00;
                end else if (ov_off) begin
                    next_state = ST_ON;
                    next_load = 1'b1;
                    next_ov_off = 1'b0;
                end else if (tick) begin
                    next_timer = timer_inc;
                    if (timer_inc >= `BLD_T_ON) begin
                        next_state = ST_ON;
                        next_load = 1'b1;
                        next_timer = 7'h00;
                    end
                end
            end
            ST_LOCK: begin
                next_load = 1'b0;
                if (!above_52) begin
                    next_timer = 7'h00;
                end else if (tick) begin
                    next_timer = timer_inc;
                    if (timer_inc >= `BLD_T_RECHARGE) begin
                        // Recharge seen: hold-off counts as already served
                        next_state = ST_OFF;
                        next_tries = 2'h0;
                        next_timer = `BLD_T_HOLD;
                    end
                end
            end
            default: begin
                next_state = ST_OFF;
                next_load = 1'b0;
                next_timer = 7'h00;
            end
        endcase
        // Leaving lithium mode clears any lock-out count
        if (!lithium && state != ST_LOCK) begin
            next_tries = 2'h0;
        end
        if (!lithium && state == ST_LOCK) begin
            next_state = ST_OFF;
            next_tries = 2'h0;
            next_timer = 7'h00;
        end
    end

    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state <= ST_OFF;
            timer <= 7'h00;
            tries <= 2'h0;
            ov_off <= 1'b0;
            load_on_o <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            tries <= next_tries;
            ov_off <= next_ov_off;
            load_on_o <= next_load;
        end
    end

    // ==========================================================
    // Alarm output
    reg next_alarm;

    always @* begin
        next_alarm = 1'b0;
        if (lithium) begin
            next_alarm = 1'b0;
        end else if (ov && !relay) begin
            next_alarm = blink;
        end else if (ov) begin
            next_alarm = 1'b0;
        end else if (state == ST_ON && uv && timer >= `BLD_T_ALARM) begin
            // Same level in both modes; the load differs, buzzer or relay coil
            next_alarm = 1'b1;
        end
    end

    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            blink <= 1'b0;
            alarm_o <= 1'b0;
        end else begin
            if (tick) begin
                blink <= ~blink;
            end
            alarm_o <= next_alarm;
        end
    end

endmodule // bld_top

`default_nettype wire

// File: bld_regs.vh
// Register map, field positions, reset values and timing counts of the load disconnect block
// Function
// - Removing the low-high remote link disconnects the load after 90 seconds.
// - Buzzer mode under-voltage: continuous alarm at 12 s, disconnect and silence at 90 s.
// - Buzzer mode: reconnect 30 seconds after an under-voltage disconnect.
// - High remote input low: off after 90 s; back high: on after 30 s.
// - Low remote input pulled to minus acts exactly like the high input.
// - Lithium mode: open discharge permit contact disconnects the load at once.
// - Lithium mode: disconnect trigger is the high input going from high to floating.
// - Lithium mode: ignore re-engage for 30 s after disconnect, then reconnect immediately.
// - Lithium mode: under-voltage thresholds ignored, alarm output kept inactive.
// - After 3 reclosing attempts stay off until above 52 V for 30 s.
// - Buzzer mode over-voltage: immediate off, intermittent alarm, reconnect with no delay.
// - Relay mode under-voltage: relay on at 12 s, disconnect and release at 90 s.
// - Relay mode over-voltage: immediate disconnect, alarm output stays inactive.
// - Three modes: buzzer default, relay second, lithium third; two steer the alarm.
// - Shutdown and restart voltages held as a pair, preset or user defined.
// - Wireless disabled by software is re-enabled only by the program pin.
`ifndef BLD_REGS_VH
`define BLD_REGS_VH

// ==========================================================
// Register byte offsets
`define BLD_OFS_CTRL 4'h0
`define BLD_OFS_LEVELS 4'h4
`define BLD_OFS_STATUS 4'h8

// ==========================================================
// Control fields
`define BLD_CTRL_MODE_LSB 0
`define BLD_CTRL_WLESS_BIT 2
`define BLD_MODE_BUZZER 2'h0
`define BLD_MODE_RELAY 2'h1
`define BLD_MODE_LITHIUM 2'h2

// ==========================================================
// Level pair fields, 0.1 V units
`define BLD_LVL_SHUT_LSB 0
`define BLD_LVL_REST_LSB 16
`define BLD_LVL_PRESET_LSB 26
`define BLD_LVL_USER_BIT 30
`define BLD_RST_SHUTDOWN 10'h1A4
`define BLD_RST_RESTART 10'h1E0

// ==========================================================
// Timing, in seconds of the tick
`define BLD_T_ALARM 7'h0C
`define BLD_T_OFF 7'h5A
`define BLD_T_ON 7'h1E
`define BLD_T_HOLD 7'h1E
`define BLD_T_RECHARGE 7'h1E
`define BLD_MAX_TRIES 2'h3
`define BLD_CLK_HZ 40000000

`endif

// File: bld_tick.v
// One-second enable pulse divided down from the system clock
`timescale 1ns/1ps
`default_nettype none

module bld_tick #(
    parameter integer CLK_HZ = 40000000
) (
    // Clock and reset
    input wire clock_i,
    input wire reset_i,
    // Tick
    output reg tick_o
);

    localparam integer LAST_I = CLK_HZ - 1;
    localparam [25:0] LAST = LAST_I[25:0];

    reg [25:0] count;

    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            count <= 26'h0000000;
            tick_o <= 1'b0;
        end else if (count >= LAST) begin
            count <= 26'h0000000;
            tick_o <= 1'b1;
        end else begin
            count <= count + 26'h0000001;
            tick_o <= 1'b0;
        end
    end

endmodule // bld_tick

`default_nettype wire

// File: bld_top_asserts.sv
// Port-level assertions of the load disconnect controller
`timescale 1ns/1ps
`default_nettype none
`include "bld_regs.vh"
module bld_top_asserts #(
    parameter integer CLK_HZ = 20
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Register bus
    input wire logic [3:0] avs_address_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic avs_waitrequest_o,
    // Pins
    input wire logic remote_high_i,
    input wire logic remote_low_n_i,
    input wire logic under_voltage_i,
    input wire logic over_voltage_i,
    input wire logic restart_ok_i,
    input wire logic program_pin_n_i,
    // Outputs
    input wire logic [9:0] shutdown_level_o,
    input wire logic [9:0] restart_level_o,
    input wire logic load_on_o,
    input wire logic alarm_o,
    input wire logic wireless_en_o
);
    // ====================
    // Cause ages on the raw pins; they lead the synchronised view by two cycles
    logic [1:0] mode;
    int mode_age, cause_cnt, ok_cnt, uv_cnt, ov_cnt, off_age;
    wire logic remote_on = remote_high_i | ~remote_low_n_i;
    wire logic lith = (mode == `BLD_MODE_LITHIUM);
    wire logic ov_q = (ov_cnt > 8);
    wire logic wr_ok = avs_write_i && !avs_waitrequest_o;
    wire logic cause = (!remote_on || under_voltage_i) && !over_voltage_i && !lith;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mode <= `BLD_MODE_BUZZER;
            mode_age <= 0;
            cause_cnt <= 0;
            ok_cnt <= 0;
            uv_cnt <= 0;
            ov_cnt <= 100;
            off_age <= 0;
        end else begin
            if (wr_ok && avs_address_i == `BLD_OFS_CTRL && avs_writedata_i[1:0] != 2'h3) begin
                mode <= avs_writedata_i[1:0];
                mode_age <= 0;
            end else begin
                mode_age <= mode_age + 1;
            end
            cause_cnt <= cause ? cause_cnt + 1 : 0;
            ok_cnt <= (remote_on && restart_ok_i) ? ok_cnt + 1 : 0;
            uv_cnt <= under_voltage_i ? uv_cnt + 1 : 0;
            ov_cnt <= over_voltage_i ? 0 : ov_cnt + 1;
            off_age <= load_on_o ? 0 : off_age + 1;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // ====================
    // Properties
    ov_forces_off_a: assert property (over_voltage_i [*4] |=> !load_on_o)
        else $error("load on during over-voltage");
    off_not_early_a: assert property ($fell(load_on_o) && !lith && ov_q
        |-> cause_cnt >= (`BLD_T_OFF - 1) * CLK_HZ) else $error("load dropped too early");
    off_not_late_a: assert property (cause_cnt > `BLD_T_OFF * CLK_HZ + 4 |-> !load_on_o)
        else $error("load still on after off delay");
    on_not_early_a: assert property ($fell(!load_on_o) && !lith && ov_q
        |-> ok_cnt >= (`BLD_T_ON - 1) * CLK_HZ) else $error("load reconnected too early");
    alarm_delay_a: assert property ($rose(alarm_o) && ov_q
        |-> uv_cnt >= (`BLD_T_ALARM - 1) * CLK_HZ) else $error("alarm raised too early");
    lith_fast_off_a: assert property ((lith && !remote_on) [*4] |=> !load_on_o)
        else $error("lithium disconnect delayed");
    lith_hold_a: assert property ($rose(load_on_o) && lith && mode_age > 3
        |-> off_age >= (`BLD_T_HOLD - 1) * CLK_HZ) else $error("hold-off not observed");
    lith_quiet_a: assert property (lith && mode_age > 3 |-> !alarm_o)
        else $error("alarm active in lithium mode");
    pin_wireless_a: assert property ($fell(program_pin_n_i) |-> ##[1:6] wireless_en_o)
        else $error("program pin did not enable wireless");
    level_pair_a: assert property (wr_ok && avs_address_i == `BLD_OFS_LEVELS
        |=> shutdown_level_o == $past(avs_writedata_i[9:0])
        && restart_level_o == $past(avs_writedata_i[25:16])) else $error("levels not stored");
endmodule // bld_top_asserts
bind bld_top bld_top_asserts #(.CLK_HZ(CLK_HZ)) bld_top_asserts_inst (.*);
`default_nettype wire

// File: bld_remote_model.sv
// Remote switch or permit contact driving the two remote pins
`timescale 1ns/1ps
`default_nettype none
module bld_remote_model (
    // Clock
    input wire logic clock_i,
    // Contact state
    input wire logic closed_i,
    input wire logic via_low_i,
    // Remote pins
    output var logic remote_high_o,
    output var logic remote_low_n_o
);
    // An open contact leaves H floating, seen low through its pull-down
    always @(posedge clock_i) begin
        remote_high_o <= closed_i && !via_low_i;
        remote_low_n_o <= !(closed_i && via_low_i);
    end
endmodule // bld_remote_model
`default_nettype wire

// File: test_battery_load_disconnect_controller.sv
// Self-checking bench of the load disconnect controller
`timescale 1ns/1ps
`default_nettype none
`include "bld_regs.vh"
module test_battery_load_disconnect_controller;
    // Short tick keeps the long delays cheap
    localparam integer CLK = 20;
    logic clock_i = 1'h0, reset_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0;
    logic [3:0] avs_address_i = 4'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd, seed = 32'h5B, ctrl = 32'h4;
    logic avs_waitrequest_o, remote_high_i, remote_low_n_i, closed = 1'h1, via_low = 1'h0;
    logic under_voltage_i = 1'h0, over_voltage_i = 1'h0, restart_ok_i = 1'h1;
    logic above_52v_i = 1'h0, program_pin_n_i = 1'h1;
    logic [9:0] shutdown_level_o, restart_level_o;
    logic load_on_o, alarm_o, wireless_en_o;
    int fails = 0, check_count = 0, hi, r;
    bld_top #(.CLK_HZ(CLK)) bld_top_inst (.*);
    bld_remote_model bld_remote_model_inst (.clock_i(clock_i), .closed_i(closed),
        .via_low_i(via_low), .remote_high_o(remote_high_i), .remote_low_n_o(remote_low_n_i));
    always #12.5 clock_i = ~clock_i;
    // ====================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [31:0] ctrl_exp(input logic [31:0] w, input logic [31:0] old);
        return {29'h0, old[2] & w[2], (w[1:0] == 2'h3) ? old[1:0] : w[1:0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            fails++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        // Request stands until the edge where waitrequest is seen low
        @(posedge clock_i);
        while (avs_waitrequest_o !== 1'h0 && n < 20) begin
            @(posedge clock_i);
            n++;
        end
        if (n == 20) fails++;
        q = avs_readdata_o;
        avs_write_i <= 1'h0;
        avs_read_i <= 1'h0;
        @(posedge clock_i);
    endtask
    task automatic set_mode(input logic [31:0] w);
        bus(1'h1, `BLD_OFS_CTRL, w, rd);
        bus(1'h0, `BLD_OFS_CTRL, 32'h0, rd);
        ctrl = ctrl_exp(w, ctrl);
        check(rd, ctrl);
    endtask
    task automatic wait_ticks(input int n);
        repeat (n * CLK) @(posedge clock_i);
    endtask
    // Output must still be at the old level two ticks early and at the new one a tick late
    task automatic edge_at(input int sel, input int t, input logic v);
        wait_ticks(t - 2);
        check(sel ? alarm_o : load_on_o, !v);
        wait_ticks(3);
        check(sel ? alarm_o : load_on_o, v);
    endtask
    // ====================
    // Scenarios
    initial begin
        repeat (5) @(posedge clock_i);
        reset_i <= 1'h0;
        edge_at(0, `BLD_T_ON, 1'h1);
        bus(1'h0, `BLD_OFS_CTRL, 32'h0, rd);
        check(rd, ctrl);
        bus(1'h0, `BLD_OFS_STATUS, 32'h0, rd);
        check(rd, 32'h00000009);
        bus(1'h0, `BLD_OFS_LEVELS, 32'h0, rd);
        check(rd, {6'h0, `BLD_RST_RESTART, 6'h0, `BLD_RST_SHUTDOWN});
        bus(1'h0, 4'hC, 32'h0, rd);
        check(rd, 32'h0);
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            bus(1'h1, `BLD_OFS_LEVELS, seed, rd);
            bus(1'h1, 4'hC, ~seed, rd);
            bus(1'h0, `BLD_OFS_LEVELS, 32'h0, rd);
            check(rd, seed & 32'h7FFF03FF);
            check(shutdown_level_o, seed[9:0]);
        end
        for (int m = 0; m < 2; m++) begin
            set_mode(32'h4 | m);
            over_voltage_i <= 1'h1;
            repeat (6) @(posedge clock_i);
            check(load_on_o, 1'h0);
            hi = 0;
            repeat (3 * CLK) begin
                @(posedge clock_i);
                hi += alarm_o;
            end
            check(hi != 0 && hi < 3 * CLK, m == 0);
            over_voltage_i <= 1'h0;
            repeat (6) @(posedge clock_i);
            check(load_on_o, 1'h1);
            under_voltage_i <= 1'h1;
            restart_ok_i <= 1'h0;
            edge_at(1, `BLD_T_ALARM, 1'h1);
            edge_at(0, `BLD_T_OFF - `BLD_T_ALARM - 1, 1'h0);
            check(alarm_o, 1'h0);
            under_voltage_i <= 1'h0;
            restart_ok_i <= 1'h1;
            edge_at(0, `BLD_T_ON, 1'h1);
        end
        for (int v = 0; v < 2; v++) begin
            via_low <= v[0];
            wait_ticks(2);
            closed <= 1'h0;
            wait_ticks(60);
            closed <= 1'h1;
            wait_ticks(1);
            check(load_on_o, 1'h1);
            closed <= 1'h0;
            edge_at(0, `BLD_T_OFF, 1'h0);
            closed <= 1'h1;
            edge_at(0, `BLD_T_ON, 1'h1);
        end
        via_low <= 1'h0;
        set_mode(32'h6);
        under_voltage_i <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            closed <= 1'h0;
            repeat (5) @(posedge clock_i);
            check(load_on_o, 1'h0);
            seed = xs(seed);
            r = seed % 20;
            wait_ticks(r);
            closed <= 1'h1;
            wait_ticks(`BLD_T_HOLD - 3 - r);
            check(load_on_o, 1'h0);
            wait_ticks(4);
            check(load_on_o, i < 3);
        end
        check(alarm_o, 1'h0);
        above_52v_i <= 1'h1;
        edge_at(0, `BLD_T_RECHARGE, 1'h1);
        set_mode(32'h2);
        check(wireless_en_o, 1'h0);
        set_mode(32'h7);
        program_pin_n_i <= 1'h0;
        repeat (8) @(posedge clock_i);
        check(wireless_en_o, 1'h1);
        finish_test;
    end
    initial begin
        repeat (40000) @(posedge clock_i);
        fails++;
        finish_test;
    end
endmodule // test_battery_load_disconnect_controller
`default_nettype wire
